// ---- design/conv_status_pkg.sv ----
package conv_status_pkg;
    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [5:0]  STATUS_ADDR     = 6'h00;
    localparam logic [5:0]  DATA_ADDR       = 6'h04;
    localparam logic [7:0]  STATUS_RESET    = 8'h80;
    localparam int          READY_BIT       = 7;
    localparam int          RANGE_ERR_BIT   = 6;
    localparam int          CSUM_ERR_BIT    = 5;
    localparam int          INTEG_ERR_BIT   = 4;
    localparam logic [23:0] RESULT_MAX_CODE = 24'h0FFFFF;
    localparam logic [23:0] RESULT_MIN_CODE = 24'h000000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        result_we;
        logic        calib_mode;
        logic        calib_we;
        logic        overrange;
        logic        underrange;
        logic [1:0]  channel;
        logic [23:0] raw_result;
    } conv_event_type;

    typedef struct packed {
        logic        status_read_start;
        logic        data_read;
        logic        reg_read_active;
        logic        csum_mismatch_wr;
        logic        append_status;
        logic        integ_check_en;
        logic        integ_mismatch;
        logic        cs_n;
    } host_event_type;

    typedef struct packed {
        logic        ready;
        logic        range_err;
        logic        csum_err;
        logic        integ_err;
        logic [1:0]  channel;
        logic [7:0]  snap;
        logic [23:0] data;
        logic        dout_rdy;
        logic        append_q;
    } status_state_type;
endpackage : conv_status_pkg

// ---- design/conv_status_reg.sv ----
// Functional notes
// - Status is 8-bit read-only, reset value 0x80, only ready set.
// - With append enabled, status follows data on each data read.
// - Chip select low and no read shifting: ready flag drives the ready pin.
// - Ready clears to 0 when a new conversion result is stored.
// - In calibration modes ready clears on calibration result write instead.
// - Ready returns to 1 when the host reads the data register, unless a result is stored in the same cycle.
// - Range error set on over/underrange; result clamped to max or zero.
// - Range error changes only on result writes; clears once condition gone.
// - Checksum error set on write checksum mismatch; reads checked by host.
// - Checksum error cleared by a status register read.
// - Integrity error set while check enabled and register content differs.
// - Integrity error cleared only when check enable is cleared.
// - Bits 1:0 give channel of result held in data register.
// - Reserved bits 3:2 always read zero.
module conv_status_reg
    import conv_status_pkg::*;
(
    input  wire logic                            i_ref_clk,
    input  wire logic                            i_reset,
    input  wire logic                            i_clk_en,
    input  wire conv_status_pkg::conv_event_type i_conv,
    input  wire conv_status_pkg::host_event_type i_host,
    output logic [7:0]                           o_status,
    output logic [7:0]                           o_status_snap,
    output logic [23:0]                          o_data,
    output logic                                 o_append_status,
    output logic                                 o_dout_rdy
);
    import conv_status_pkg::*;

    status_state_type s_q;
    status_state_type s_d;
    logic [7:0]       cur_status;
    logic             store;

    // ------------------------------------------------------------
    // Status assembly
    // ------------------------------------------------------------
    always_comb begin
        cur_status = {s_q.ready, s_q.range_err, s_q.csum_err, s_q.integ_err,
                      2'h0, s_q.channel};
        store = i_conv.calib_mode ? i_conv.calib_we : i_conv.result_we;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // Snapshot before any read side effect lands
        if (i_host.status_read_start) begin
            s_d.snap = cur_status;
        end
        if (i_host.data_read) begin
            s_d.ready = 1'b1;
            s_d.snap  = cur_status;
        end
        s_d.append_q = i_host.append_status;
        // New result wins over a data read in the same cycle
        if (store) begin
            s_d.ready = 1'b0;
        end
        if (i_conv.result_we && !i_conv.calib_mode) begin
            s_d.range_err = i_conv.overrange | i_conv.underrange;
            s_d.channel   = i_conv.channel;
            if (i_conv.overrange) begin
                s_d.data = RESULT_MAX_CODE;
            end else if (i_conv.underrange) begin
                s_d.data = RESULT_MIN_CODE;
            end else begin
                s_d.data = i_conv.raw_result;
            end
        end
        if (i_host.status_read_start) begin
            s_d.csum_err = 1'b0;
        end
        // Set beats clear
        if (i_host.csum_mismatch_wr) begin
            s_d.csum_err = 1'b1;
        end
        if (!i_host.integ_check_en) begin
            s_d.integ_err = 1'b0;
        end else if (i_host.integ_mismatch) begin
            s_d.integ_err = 1'b1;
        end
        // Pin mirrors next ready; idles high when deselected or shifting
        if (!i_host.cs_n && !i_host.reg_read_active) begin
            s_d.dout_rdy = s_d.ready;
        end else begin
            s_d.dout_rdy = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            s_q           <= '0;
            s_q.ready     <= STATUS_RESET[READY_BIT];
            s_q.snap      <= STATUS_RESET;
            s_q.dout_rdy  <= 1'b1;
        end else if (i_clk_en) begin
            s_q <= s_d;
        end
    end

    always_comb begin
        o_status        = {s_q.ready, s_q.range_err, s_q.csum_err, s_q.integ_err,
                           2'h0, s_q.channel};
        o_status_snap   = s_q.snap;
        o_data          = s_q.data;
        o_append_status = s_q.append_q;
        o_dout_rdy      = s_q.dout_rdy;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_reset_value;
        @(posedge i_ref_clk)
        $past(i_reset) |-> o_status == STATUS_RESET && o_status_snap == STATUS_RESET;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("bad reset");

    property p_ready_clear;
        @(posedge i_ref_clk) disable iff (i_reset)
        (i_clk_en && store) |=> !o_status[7];
    endproperty
    a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared");

    property p_ready_set;
        @(posedge i_ref_clk) disable iff (i_reset)
        (i_clk_en && i_host.data_read && !store) |=> o_status[7];
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready not set");

    property p_pin;
        @(posedge i_ref_clk) disable iff (i_reset)
        (i_clk_en && !i_host.cs_n && !i_host.reg_read_active) |=> o_dout_rdy == o_status[7];
    endproperty
    a_pin: assert property (p_pin) else $error("pin mismatch");

    property p_clamp;
        @(posedge i_ref_clk) disable iff (i_reset)
        (i_clk_en && i_conv.result_we && !i_conv.calib_mode && i_conv.overrange)
            |=> o_data == RESULT_MAX_CODE && o_status[RANGE_ERR_BIT];
    endproperty
    a_clamp: assert property (p_clamp) else $error("no clamp");

    property p_range_hold;
        @(posedge i_ref_clk) disable iff (i_reset)
        !(i_clk_en && i_conv.result_we) |=> $stable(o_status[6]);
    endproperty
    a_range_hold: assert property (p_range_hold) else $error("range moved");

    property p_csum;
        @(posedge i_ref_clk) disable iff (i_reset)
        (i_clk_en && i_host.csum_mismatch_wr) |=> o_status[5];
    endproperty
    a_csum: assert property (p_csum) else $error("csum lost");

    property p_csum_clr;
        @(posedge i_ref_clk) disable iff (i_reset)
        (i_clk_en && i_host.status_read_start && !i_host.csum_mismatch_wr)
            |=> !o_status[5] && o_status_snap[5] == $past(o_status[5]);
    endproperty
    a_csum_clr: assert property (p_csum_clr) else $error("csum clear");

    property p_integ;
        @(posedge i_ref_clk) disable iff (i_reset)
        (i_clk_en && !i_host.integ_check_en) |=> !o_status[4];
    endproperty
    a_integ: assert property (p_integ) else $error("integ clear");

    property p_resv;
        @(posedge i_ref_clk) o_status[3:2] == 2'h0 && o_status_snap[3:2] == 2'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved set");

    property p_calib_ready;
        @(posedge i_ref_clk) disable iff (i_reset)
        (i_clk_en && i_conv.calib_mode && i_conv.calib_we) |=> !o_status[READY_BIT];
    endproperty
    a_calib_ready: assert property (p_calib_ready) else $error("calib ready");

    // Calibration writes must leave the held result and its tags alone
    property p_calib_refuse;
        @(posedge i_ref_clk) disable iff (i_reset)
        (i_clk_en && i_conv.calib_mode)
            |=> $stable(o_data) && $stable(o_status[RANGE_ERR_BIT]) && $stable(o_status[1:0]);
    endproperty
    a_calib_refuse: assert property (p_calib_refuse) else $error("calib refuse");

    property p_channel;
        @(posedge i_ref_clk) disable iff (i_reset)
        (i_clk_en && i_conv.result_we && !i_conv.calib_mode)
            |=> o_status[1:0] == $past(i_conv.channel);
    endproperty
    a_channel: assert property (p_channel) else $error("channel");

    property p_underclamp;
        @(posedge i_ref_clk) disable iff (i_reset)
        (i_clk_en && i_conv.result_we && !i_conv.calib_mode &&
         i_conv.underrange && !i_conv.overrange)
            |=> o_data == RESULT_MIN_CODE && o_status[RANGE_ERR_BIT];
    endproperty
    a_underclamp: assert property (p_underclamp) else $error("no zero clamp");

    // Appended byte is the status seen before the read set ready
    property p_append;
        @(posedge i_ref_clk) disable iff (i_reset)
        (i_clk_en && i_host.data_read)
            |=> o_status_snap == $past(o_status) &&
                o_append_status == $past(i_host.append_status);
    endproperty
    a_append: assert property (p_append) else $error("append frame");

    property p_status_snap;
        @(posedge i_ref_clk) disable iff (i_reset)
        (i_clk_en && i_host.status_read_start) |=> o_status_snap == $past(o_status);
    endproperty
    a_status_snap: assert property (p_status_snap) else $error("status snap");

    property p_integ_set;
        @(posedge i_ref_clk) disable iff (i_reset)
        (i_clk_en && i_host.integ_check_en && i_host.integ_mismatch)
            |=> o_status[INTEG_ERR_BIT];
    endproperty
    a_integ_set: assert property (p_integ_set) else $error("integ lost");

    property p_pin_idle;
        @(posedge i_ref_clk) disable iff (i_reset)
        (i_clk_en && (i_host.cs_n || i_host.reg_read_active)) |=> o_dout_rdy;
    endproperty
    a_pin_idle: assert property (p_pin_idle) else $error("pin not idle");

    // Enable low must freeze every output, not only the flags
    property p_freeze;
        @(posedge i_ref_clk) disable iff (i_reset)
        !i_clk_en |=> $stable(o_status) && $stable(o_status_snap) && $stable(o_data) &&
                      $stable(o_append_status) && $stable(o_dout_rdy);
    endproperty
    a_freeze: assert property (p_freeze) else $error("not frozen");
endmodule : conv_status_reg

// ---- testbench/host_model.sv ----
module host_model
    import conv_status_pkg::*;
(
    input  wire logic                       i_ref_clk,
    output conv_status_pkg::host_event_type o_host
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] comms_q;
    // ----------------------------------------
    // Host transfers
    // ----------------------------------------
    // Selected from time zero; cs_n is pulsed high only to probe the pin
    initial begin
        o_host  = '0;
        comms_q = 8'h00;
    end
    task automatic pulse(input logic [7:0] mask);
        @(posedge i_ref_clk) o_host <= host_event_type'(o_host | mask);
        @(posedge i_ref_clk) o_host <= host_event_type'(o_host & ~mask);
    endtask : pulse
    task automatic level(input logic [7:0] mask, input logic on);
        @(posedge i_ref_clk) o_host <= on ? host_event_type'(o_host | mask)
                                          : host_event_type'(o_host & ~mask);
        @(posedge i_ref_clk);
    endtask : level
    task automatic read_reg(input logic [5:0] register_select);
        @(posedge i_ref_clk) comms_q <= {2'h1, register_select};
        @(negedge i_ref_clk);
        // Only a read command becomes a read event
        if (comms_q[6] && comms_q[5:0] == STATUS_ADDR) begin
            pulse(8'hA0);
        end else if (comms_q[6] && comms_q[5:0] == DATA_ADDR) begin
            pulse(8'h60);
        end
    endtask : read_reg
endmodule : host_model

// ---- testbench/adc_status_register_tb_top.sv ----
module adc_status_register_tb_top
    import conv_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic           ref_clk;
    logic           reset;
    logic           clk_en;
    conv_event_type conv;
    host_event_type host;
    logic [7:0]     status;
    logic [7:0]     snap;
    logic [23:0]    data;
    logic           append;
    logic           dout_rdy;
    int             err_total;
    int             tests_run;
    int             cycles;
    conv_status_reg conv_status_reg_inst (.i_ref_clk(ref_clk), .i_reset(reset),
        .i_clk_en(clk_en), .i_conv(conv), .i_host(host), .o_status(status),
        .o_status_snap(snap), .o_data(data), .o_append_status(append), .o_dout_rdy(dout_rdy));
    host_model host_model_inst (.i_ref_clk(ref_clk), .o_host(host));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic finish_test;
        $display("compares %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    // Hang guard, generous against the fewer than one hundred cycles the tests need
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Flags are {result_we, calib_mode, calib_we, overrange, underrange}
    task automatic res(input logic [4:0] flags, input logic [1:0] ch, input logic [23:0] raw);
        @(posedge ref_clk) conv <= {flags, ch, raw};
        @(posedge ref_clk) conv <= {1'b0, flags[3], 1'b0, flags[1:0], ch, raw};
        @(negedge ref_clk);
    endtask : res
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_result;
        chk(24'(status), 24'h80);
        chk(24'(snap), 24'h80);
        chk(24'(dout_rdy), 24'h1);
        res(5'b10010, 2'h3, 24'h123456);
        chk(24'(status), 24'h43);
        chk(data, 24'h0FFFFF);
        chk(24'(dout_rdy), 24'h0);
        host_model_inst.pulse(8'h01);
        @(negedge ref_clk);
        chk(24'(dout_rdy), 24'h1);
        res(5'b10001, 2'h1, 24'h000010);
        chk(24'(status), 24'h41);
        chk(data, 24'h000000);
        res(5'b10000, 2'h2, 24'h0ABCDE);
        chk(24'(status), 24'h02);
        host_model_inst.level(8'h08, 1'b1);
        host_model_inst.read_reg(DATA_ADDR);
        @(negedge ref_clk);
        chk(24'(status), 24'h82);
        chk(24'(snap), 24'h02);
        chk(data, 24'h0ABCDE);
        chk(24'(append), 24'h1);
        $display("result test done");
    endtask : t_result
    task automatic t_flags;
        host_model_inst.pulse(8'h10);
        @(negedge ref_clk);
        chk(24'(status), 24'hA2);
        host_model_inst.read_reg(STATUS_ADDR);
        @(negedge ref_clk);
        chk(24'(snap), 24'hA2);
        chk(24'(status), 24'h82);
        host_model_inst.level(8'h04, 1'b1);
        host_model_inst.pulse(8'h02);
        @(negedge ref_clk);
        chk(24'(status), 24'h92);
        host_model_inst.level(8'h04, 1'b0);
        @(negedge ref_clk);
        chk(24'(status), 24'h82);
        res(5'b11000, 2'h0, 24'h000001);
        chk(24'(status[7]), 24'h1);
        chk(data, 24'h0ABCDE);
        chk(24'(status), 24'h82);
        res(5'b01100, 2'h0, 24'h000001);
        chk(24'(status[7]), 24'h0);
        $display("flag test done");
    endtask : t_flags
    task automatic t_freeze;
        @(posedge ref_clk) clk_en <= 1'b0;
        res(5'h12, 2'h1, 24'h000005);
        chk(24'(status), 24'h02);
        chk(data, 24'h0ABCDE);
        @(posedge ref_clk) clk_en <= 1'b1;
        // Result store and data read land on the same edge
        fork
            res(5'h10, 2'h1, 24'h000005);
            host_model_inst.pulse(8'h60);
        join
        chk(24'(status), 24'h01);
        chk(24'(snap), 24'h02);
        chk(data, 24'h000005);
        host_model_inst.pulse(8'hB0);
        @(negedge ref_clk);
        chk(24'(status), 24'h21);
        chk(24'(snap), 24'h01);
        @(posedge ref_clk) reset <= 1'b1;
        @(posedge ref_clk) reset <= 1'b0;
        @(negedge ref_clk);
        chk(24'(status), 24'h80);
        chk(24'(snap), 24'h80);
        chk(data, 24'h000000);
        chk(24'(dout_rdy), 24'h1);
        $display("freeze and reset test done");
    endtask : t_freeze
    initial begin
        err_total = 0;
        tests_run = 0;
        cycles    = 0;
        clk_en    = 1'b1;
        conv      = '0;
        reset     = 1'b1;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        @(negedge ref_clk);
        t_result();
        t_flags();
        t_freeze();
        finish_test();
    end
endmodule : adc_status_register_tb_top
